//--- logic/red_pkg.sv
// constants and types for the remote event dispatcher
package red_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int FLASH_HALF_MS = 500;
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
   localparam int TEXT_MAX = 40;
   localparam logic [4:0] MASTER_GROUP = 5'h00;
   // register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_LOGCNT = 4'h8;
   localparam logic [3:0] REG_LAST = 4'hc;
   // control fields
   localparam int CTRL_GROUP_LSB = 0;
   localparam int CTRL_GRPDEF_BIT = 5;
   localparam int CTRL_GLOBAL_BIT = 6;
   localparam int CTRL_SERIAL_BIT = 7;
   localparam int CTRL_ANN_BIT = 8;
   localparam int CTRL_RDM_BIT = 9;
   localparam logic [9:0] CTRL_RESET = 10'h0_380;
   typedef enum logic [2:0] {
      RED_TRB = 3'h0,
      RED_ALM = 3'h1,
      RED_STG = 3'h2,
      RED_VER = 3'h3,
      RED_SUP = 3'h4,
      RED_PRE = 3'h5
   } red_class_t;
endpackage

//--- logic/red_dispatcher.sv
// remote event dispatcher with classic wishbone register slave
`timescale 1ns/1ps
module red_dispatcher import red_pkg::*; #(
   parameter int P_FLASH_CYC = FLASH_HALF_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_evt_valid,
   input wire logic [2:0] i_evt_class,
   input wire logic [4:0] i_evt_group,
   input wire logic [5:0] i_evt_node,
   input wire logic [7:0] i_evt_addr,
   input wire logic [3:0] i_evt_state,
   input wire logic [3:0] i_evt_dtype,
   input wire logic i_rcmd_valid,
   input wire logic [1:0] i_rcmd_kind,
   input wire logic [4:0] i_rcmd_group,
   input wire logic i_key_ack,
   input wire logic i_key_sil,
   input wire logic i_key_rst,
   input wire logic i_local_timer_run,
   output logic o_lamp_alarm,
   output logic o_lamp_pre,
   output logic o_lamp_trouble,
   output logic o_lamp_super,
   output logic o_lamp_silence,
   output logic o_buzzer,
   output logic o_trouble_relay,
   output logic o_log_valid,
   output logic [2:0] o_log_class,
   output logic [5:0] o_log_node,
   output logic [7:0] o_log_addr,
   output logic o_fwd_net,
   output logic o_fwd_serial,
   output logic o_fwd_rdm,
   output logic o_fwd_ann,
   output logic [3:0] o_out_act,
   output logic o_silence,
   output logic o_restore,
   output logic o_disp_update,
   output logic [5:0] o_disp_node,
   output logic [7:0] o_disp_addr,
   output logic [3:0] o_disp_state,
   output logic [3:0] o_disp_dtype,
   output logic [5:0] o_disp_text_len,
   output logic o_disp_timer_en
);
   initial begin
      if (P_FLASH_CYC < 2) begin
         $error("P_FLASH_CYC must be at least 2");
      end
   end

   logic [9:0] ctrl_reg;
   logic [4:0] own_grp;
   logic grp_def;
   logic master;
   logic evt_app;
   logic cmd_app;
   logic [2:0] key_s1_reg;
   logic [2:0] key_s2_reg;
   logic [2:0] key_s3_reg;
   logic [2:0] key_pulse;
   logic do_ack;
   logic do_sil;
   logic do_rst;
   logic [5:0] act_reg;
   logic [5:0] unack_reg;
   logic [5:0] evt_hot;
   logic silenced_reg;
   logic [31:0] flash_cnt_reg;
   logic flash_reg;
   logic [15:0] logcnt_reg;
   logic [2:0] disp_cls_reg;
   logic disp_remote_reg;
   logic steady_req;
   logic pulse_req;
   logic is_main;

   assign own_grp = ctrl_reg[CTRL_GROUP_LSB +: 5];
   assign grp_def = ctrl_reg[CTRL_GRPDEF_BIT];
   assign master = grp_def && own_grp == MASTER_GROUP;
   // group 0 only means master once groups exist
   assign evt_app = i_evt_valid && (master || !grp_def ||
      ctrl_reg[CTRL_GLOBAL_BIT] || i_evt_group == own_grp);
   assign cmd_app = i_rcmd_valid && (master || !grp_def ||
      ctrl_reg[CTRL_GLOBAL_BIT] || i_rcmd_group == own_grp);

   // key pins are asynchronous: two stages, then edge detect on stage two
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         key_s1_reg <= 3'h0;
         key_s2_reg <= 3'h0;
         key_s3_reg <= 3'h0;
      end else begin
         key_s1_reg <= {i_key_rst, i_key_sil, i_key_ack};
         key_s2_reg <= key_s1_reg;
         key_s3_reg <= key_s2_reg;
      end
   end
   assign key_pulse = key_s2_reg & ~key_s3_reg;
   // local keys always act; remote commands only when in scope
   assign do_ack = key_pulse[0] || (cmd_app && i_rcmd_kind == 2'h0);
   assign do_sil = key_pulse[1] || (cmd_app && i_rcmd_kind == 2'h1);
   assign do_rst = key_pulse[2] || (cmd_app && i_rcmd_kind == 2'h2);

   always_comb begin
      evt_hot = 6'h00;
      if (evt_app && i_evt_class <= 3'h5) begin
         evt_hot[i_evt_class] = 1'b1;
      end
   end
   assign is_main = evt_app && (i_evt_class == RED_TRB ||
      i_evt_class == RED_ALM || i_evt_class == RED_SUP ||
      i_evt_class == RED_PRE);

   // wishbone slave: ack one cycle after the strobe, dropped next cycle
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
         o_wb_dat <= 32'h0000_0000;
         if (i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we) begin
            case (i_wb_adr)
               REG_CTRL: o_wb_dat <= {22'h00_0000, ctrl_reg};
               REG_STATUS: o_wb_dat <= {16'h0000, disp_cls_reg,
                  silenced_reg, unack_reg, act_reg};
               REG_LOGCNT: o_wb_dat <= {16'h0000, logcnt_reg};
               REG_LAST: o_wb_dat <= {6'h00, o_disp_dtype, o_disp_state,
                  o_disp_addr, o_disp_node, 1'b0, disp_cls_reg};
               default: o_wb_dat <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we &&
            i_wb_adr == REG_CTRL) begin
         if (i_wb_sel[0]) begin
            ctrl_reg[7:0] <= i_wb_dat[7:0];
         end
         if (i_wb_sel[1]) begin
            ctrl_reg[9:8] <= i_wb_dat[9:8];
         end
      end
   end

   // active and unacknowledged flags: a new event wins over a clear
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         act_reg <= 6'h00;
         unack_reg <= 6'h00;
      end else begin
         act_reg <= (do_rst ? 6'h00 : act_reg) | evt_hot;
         unack_reg <= (do_ack ? 6'h00 : unack_reg) | evt_hot;
      end
   end

   // silence holds until a new main event re-sounds silenced outputs or a reset clears it
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         silenced_reg <= 1'b0;
      end else if (is_main || do_rst) begin
         silenced_reg <= 1'b0;
      end else if (do_sil) begin
         silenced_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_reg <= 1'b0;
      end else if (flash_cnt_reg >= 32'(P_FLASH_CYC - 1)) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_reg <= !flash_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      end
   end

   // class lamps flash while unacknowledged, then steady until reset; silence lamp follows silence
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_lamp_alarm <= 1'b0;
         o_lamp_pre <= 1'b0;
         o_lamp_trouble <= 1'b0;
         o_lamp_super <= 1'b0;
         o_lamp_silence <= 1'b0;
      end else begin
         o_lamp_alarm <= act_reg[RED_ALM] &&
            (!unack_reg[RED_ALM] || flash_reg);
         o_lamp_pre <= act_reg[RED_PRE] &&
            (!unack_reg[RED_PRE] || flash_reg);
         o_lamp_trouble <= act_reg[RED_TRB] &&
            (!unack_reg[RED_TRB] || flash_reg);
         o_lamp_super <= act_reg[RED_SUP] &&
            (!unack_reg[RED_SUP] || flash_reg);
         o_lamp_silence <= silenced_reg;
      end
   end

   // staged delay and verification only pulse the buzzer, no lamp
   assign steady_req = unack_reg[RED_ALM];
   assign pulse_req = |{unack_reg[RED_TRB], unack_reg[RED_STG],
      unack_reg[RED_VER], unack_reg[RED_SUP],
      unack_reg[RED_PRE]};
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_buzzer <= 1'b0;
      end else begin
         o_buzzer <= steady_req || (pulse_req && flash_reg);
      end
   end

   // relay is energized in normal state; drops while trouble is active
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_trouble_relay <= 1'b1;
      end else begin
         o_trouble_relay <= !act_reg[RED_TRB];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_log_valid <= 1'b0;
         o_log_class <= 3'h0;
         o_log_node <= 6'h00;
         o_log_addr <= 8'h00;
         logcnt_reg <= 16'h0000;
      end else begin
         o_log_valid <= evt_app;
         if (evt_app) begin
            o_log_class <= i_evt_class;
            o_log_node <= i_evt_node;
            o_log_addr <= i_evt_addr;
            logcnt_reg <= logcnt_reg + 16'h0001;
         end
      end
   end

   // forwarding; annunciators only take the four main classes
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_fwd_net <= 1'b0;
         o_fwd_serial <= 1'b0;
         o_fwd_rdm <= 1'b0;
         o_fwd_ann <= 1'b0;
      end else begin
         o_fwd_net <= evt_app;
         o_fwd_serial <= evt_app && ctrl_reg[CTRL_SERIAL_BIT];
         o_fwd_rdm <= evt_app && ctrl_reg[CTRL_RDM_BIT];
         o_fwd_ann <= is_main && ctrl_reg[CTRL_ANN_BIT];
      end
   end

   // output activation bit order: trouble, alarm, supervisory, pre-alarm
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_out_act <= 4'h0;
         o_silence <= 1'b0;
         o_restore <= 1'b0;
      end else begin
         o_out_act <= {evt_hot[RED_PRE], evt_hot[RED_SUP],
            evt_hot[RED_ALM], evt_hot[RED_TRB]};
         o_silence <= do_sil && !is_main;
         o_restore <= do_rst;
      end
   end

   function automatic logic [2:0] red_prio(input logic [2:0] cls);
      case (cls)
         RED_ALM: red_prio = 3'h5;
         RED_STG: red_prio = 3'h4;
         RED_PRE: red_prio = 3'h3;
         RED_VER: red_prio = 3'h3;
         RED_SUP: red_prio = 3'h2;
         default: red_prio = 3'h1;
      endcase
   endfunction

   // a lower class does not displace a higher one still active
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_disp_update <= 1'b0;
         o_disp_node <= 6'h00;
         o_disp_addr <= 8'h00;
         o_disp_state <= 4'h0;
         o_disp_dtype <= 4'h0;
         disp_cls_reg <= 3'h0;
         disp_remote_reg <= 1'b0;
      end else begin
         o_disp_update <= 1'b0;
         if (do_rst) begin
            disp_remote_reg <= 1'b0;
         end
         if (evt_app && (!act_reg[disp_cls_reg] ||
               red_prio(i_evt_class) >= red_prio(disp_cls_reg))) begin
            o_disp_update <= 1'b1;
            o_disp_node <= i_evt_node;
            o_disp_addr <= i_evt_addr;
            o_disp_state <= i_evt_state;
            o_disp_dtype <= i_evt_dtype;
            disp_cls_reg <= i_evt_class;
            disp_remote_reg <= 1'b1;
         end
      end
   end

   // the text line is looked up by address outside; length is bounded
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_disp_text_len <= 6'h00;
         o_disp_timer_en <= 1'b0;
      end else begin
         o_disp_text_len <= 6'(TEXT_MAX);
         // remote countdowns never show time left
         o_disp_timer_en <= i_local_timer_run && !disp_remote_reg;
      end
   end

   // ---- assertions
   a_alarm_buzz_steady: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      evt_app && i_evt_class == RED_ALM |-> ##3 o_buzzer[*3])
      else $error("alarm buzzer not steady");
   a_relay_drop: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      evt_app && i_evt_class == RED_TRB && !do_rst
      |-> ##3 !o_trouble_relay)
      else $error("trouble relay did not drop");
   a_log_every: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      evt_app |=> o_log_valid && o_log_node == $past(i_evt_node))
      else $error("applicable event not logged");
   a_no_foreign: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      i_evt_valid && grp_def && !master && !ctrl_reg[CTRL_GLOBAL_BIT]
      && i_evt_group != own_grp |=> !o_log_valid && !o_fwd_net)
      else $error("foreign event accepted");
   a_stage_no_out: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      evt_app && (i_evt_class == RED_STG || i_evt_class == RED_VER)
      |=> o_out_act == 4'h0 && !o_fwd_ann)
      else $error("staged event drove outputs");
   a_trb_outputs: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      evt_app && i_evt_class == RED_TRB |=> o_out_act[0])
      else $error("trouble outputs not activated");
   a_resound: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      is_main |=> !silenced_reg)
      else $error("silenced outputs not re-sounded");
   a_lamp_scope: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      !act_reg[RED_ALM] |=> !o_lamp_alarm)
      else $error("alarm lamp lit without event");
   a_remote_timer: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      evt_app && (i_evt_class == RED_STG || i_evt_class == RED_VER)
      |-> ##3 !o_disp_timer_en)
      else $error("remote countdown shown");
   a_wb_ack_once: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn)
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");
   c_alarm: cover property (@(posedge i_sys_clk)
      disable iff (!i_resetn) evt_app && i_evt_class == RED_ALM);
   c_trouble_ack: cover property (@(posedge i_sys_clk)
      disable iff (!i_resetn) act_reg[RED_TRB] && do_ack);
   c_silence: cover property (@(posedge i_sys_clk)
      disable iff (!i_resetn) do_sil ##1 silenced_reg);
   c_remote_cmd: cover property (@(posedge i_sys_clk)
      disable iff (!i_resetn) cmd_app && i_rcmd_kind == 2'h2);
endmodule

//--- dv/red_peer_model.sv
// peer control unit model that feeds remote events into the dispatcher
`timescale 1ns/1ps
module red_peer_model (
   input wire logic i_sys_clk,
   output logic o_evt_valid,
   output logic [2:0] o_evt_class,
   output logic [4:0] o_evt_group,
   output logic [21:0] o_evt_fields
);
   initial begin
      o_evt_valid = 1'b0;
      o_evt_class = 3'h0;
      o_evt_group = 5'h00;
      o_evt_fields = 22'h00_0000;
   end
   // fields: node, address, state, device type packed high to low
   task automatic send(input logic [2:0] cls, input logic [4:0] grp,
                       input logic [21:0] fld);
      @(posedge i_sys_clk);
      o_evt_valid <= 1'b1;
      o_evt_class <= cls;
      o_evt_group <= grp;
      o_evt_fields <= fld;
      @(posedge i_sys_clk);
      o_evt_valid <= 1'b0;
      // outside a report the lines carry no stale copy of the last one
      o_evt_class <= ~cls;
      o_evt_group <= ~grp;
      o_evt_fields <= ~fld;
   endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the remote event dispatcher
`timescale 1ns/1ps
module tb_top import red_pkg::*; ();
   logic clk = 1'b0;
   logic sys_resetn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic rc_valid = 1'b0;
   logic [1:0] rc_kind = 2'h3;
   logic [4:0] rc_group = 5'h00;
   logic [2:0] keys = 3'h0;
   logic local_run = 1'b1;
   logic ev_valid;
   logic [2:0] ev_class;
   logic [4:0] ev_group;
   logic [21:0] ev_fld;
   logic [31:0] q;
   logic [31:0] ctrl;
   logic [31:0] rnd_s = 32'h0001_1e64;
   logic [21:0] exp_disp;
   logic sil_seen;
   logic rst_seen;
   int cnt;
   int hits[7];
   int n_errors = 0;
   int compares = 0;
   logic [31:0] wb_dat;
   logic wb_ack;
   logic lmp_a, lmp_p, lmp_t, lmp_s, lmp_q, buz, relay, log_v, d_upd, t_en;
   logic f_net, f_ser, f_rdm, f_ann, sil, rst;
   logic [2:0] log_c;
   logic [5:0] log_n, d_node, t_len;
   logic [7:0] log_a, d_addr;
   logic [3:0] act, d_state, d_dtype;

   always #12.5 clk = ~clk;

   red_peer_model u_red_peer_model (.i_sys_clk(clk), .o_evt_valid(ev_valid),
      .o_evt_class(ev_class), .o_evt_group(ev_group), .o_evt_fields(ev_fld));

   red_dispatcher #(.P_FLASH_CYC(4)) u_red_dispatcher (.i_sys_clk(clk),
      .i_resetn(sys_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(wb_dat),
      .o_wb_ack(wb_ack), .i_evt_valid(ev_valid), .i_evt_class(ev_class),
      .i_evt_group(ev_group), .i_evt_node(ev_fld[21:16]),
      .i_evt_addr(ev_fld[15:8]), .i_evt_state(ev_fld[7:4]),
      .i_evt_dtype(ev_fld[3:0]), .i_rcmd_valid(rc_valid),
      .i_rcmd_kind(rc_kind), .i_rcmd_group(rc_group), .i_key_ack(keys[0]),
      .i_key_sil(keys[1]), .i_key_rst(keys[2]),
      .i_local_timer_run(local_run), .o_lamp_alarm(lmp_a), .o_lamp_pre(lmp_p),
      .o_lamp_trouble(lmp_t), .o_lamp_super(lmp_s), .o_lamp_silence(lmp_q),
      .o_buzzer(buz), .o_trouble_relay(relay), .o_log_valid(log_v),
      .o_log_class(log_c), .o_log_node(log_n), .o_log_addr(log_a),
      .o_fwd_net(f_net), .o_fwd_serial(f_ser), .o_fwd_rdm(f_rdm),
      .o_fwd_ann(f_ann), .o_out_act(act), .o_silence(sil), .o_restore(rst),
      .o_disp_update(d_upd), .o_disp_node(d_node), .o_disp_addr(d_addr),
      .o_disp_state(d_state), .o_disp_dtype(d_dtype),
      .o_disp_text_len(t_len), .o_disp_timer_en(t_en));

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // reference acceptance: master, no groups, global mode or same group
   function automatic logic applies(input logic [4:0] g);
      return !ctrl[5] || ctrl[6] || ctrl[4:0] == 5'h00 || g == ctrl[4:0];
   endfunction
   function automatic logic [31:0] act_of(input logic [2:0] c);
      return c == 3'h0 ? 1 : c == 3'h1 ? 2 : c == 3'h4 ? 4 : c == 3'h5 ? 8 : 0;
   endfunction
   function automatic int lamp_of(input int c);
      return c == 0 ? 2 : c == 1 ? 0 : c == 4 ? 3 : c == 5 ? 1 : 7;
   endfunction

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
      q = wb_dat;
      if (w && a == REG_CTRL) ctrl = d;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic hw_reset();
      @(posedge clk);
      sys_resetn <= 1'b0;
      repeat (20) @(posedge clk);
      sys_resetn <= 1'b1;
      ctrl = 32'h0000_0380;
      cnt = 0;
      // let the first two edges after release pass before looking
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic ev(input int c, input logic [4:0] g, input logic dsp);
      logic [2:0] k;
      logic ap;
      logic m;
      k = 3'(c);
      ap = applies(g);
      m = act_of(k) != 0;
      rnd_s = lfsr(rnd_s);
      u_red_peer_model.send(k, g, rnd_s[21:0]);
      @(negedge clk);
      chk_bit(log_v, ap);
      chk_bit(f_net, ap);
      chk_bit(f_ser, ap & ctrl[7]);
      chk_bit(f_rdm, ap & ctrl[9]);
      chk_bit(f_ann, ap & ctrl[8] & m);
      chk_word(32'(act), ap ? act_of(k) : 0);
      chk_bit(d_upd, ap & dsp);
      if (ap) begin
         cnt++;
         if (dsp) exp_disp = rnd_s[21:0];
         chk_word(32'({log_c, log_n, log_a}), 32'({k, rnd_s[21:8]}));
         chk_word(32'({d_node, d_addr, d_state, d_dtype}), 32'(exp_disp));
      end
   endtask
   task automatic rcmd(input logic [1:0] k, input logic [4:0] g);
      logic ap;
      ap = applies(g);
      @(posedge clk);
      rc_valid <= 1'b1;
      rc_kind <= k;
      rc_group <= g;
      @(posedge clk);
      rc_valid <= 1'b0;
      rc_kind <= ~k;
      rc_group <= ~g;
      @(negedge clk);
      chk_bit(sil, ap & (k == 2'h1));
      chk_bit(rst, ap & (k == 2'h2));
   endtask
   task automatic look();
      logic [6:0] o;
      for (int i = 0; i < 7; i++) hits[i] = 0;
      repeat (12) begin
         @(negedge clk);
         o = {relay, buz, lmp_q, lmp_s, lmp_t, lmp_p, lmp_a};
         for (int i = 0; i < 7; i++) hits[i] += (o[i] === 1'b1);
      end
   endtask
   task automatic key(input int k);
      sil_seen = 1'b0;
      rst_seen = 1'b0;
      @(posedge clk);
      keys <= 3'(1 << k);
      repeat (8) begin
         @(negedge clk);
         sil_seen |= (sil === 1'b1);
         rst_seen |= (rst === 1'b1);
      end
      @(posedge clk);
      keys <= 3'h0;
      repeat (4) @(negedge clk);
   endtask

   initial begin
      #(25 * 20000);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      hw_reset();
      chk_word(32'(t_len), 32'h0000_0028);
      chk_bit(t_en, 1'b1);
      wb(1'b0, REG_CTRL, 32'h0000_0000);
      chk_word(q, 32'h0000_0380);
      wb(1'b0, 4'h2, 32'h0000_0000);
      chk_word(q, 32'h0000_0000);
      wb(1'b1, REG_STATUS, 32'hffff_ffff);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      chk_word(q, 32'h0000_0000);
      $display("test registers done");
      for (int c = 0; c < 6; c++) begin
         hw_reset();
         // a silence first, so the outputs below were silenced earlier
         rcmd(2'h1, 5'h03);
         ev(c, 5'h07, 1'b1);
         look();
         for (int j = 0; j < 4; j++)
            chk_bit(hits[j] > 0 && hits[j] < 12, j == lamp_of(c));
         chk_bit(c == 1 ? hits[5] == 12 : hits[5] > 0 && hits[5] < 12, 1'b1);
         chk_word(32'(hits[6]), c == 0 ? 0 : 12);
         chk_bit(t_en, 1'b0);
      end
      $display("test classes done");
      hw_reset();
      wb(1'b1, REG_CTRL, 32'h0000_03a5);
      ev(0, 5'h05, 1'b1);
      ev(4, 5'h06, 1'b1);
      ev(5, 5'h00, 1'b1);
      wb(1'b1, REG_CTRL, 32'h0000_03a0);
      ev(1, 5'h1f, 1'b1);
      wb(1'b1, REG_CTRL, 32'h0000_03e5);
      ev(3, 5'h09, 1'b0);
      wb(1'b1, REG_CTRL, 32'h0000_0025);
      ev(5, 5'h05, 1'b0);
      wb(1'b0, REG_LOGCNT, 32'h0000_0000);
      chk_word(q, 32'(cnt));
      rcmd(2'h1, 5'h06);
      rcmd(2'h1, 5'h05);
      rcmd(2'h2, 5'h06);
      rcmd(2'h2, 5'h05);
      wb(1'b1, REG_CTRL, 32'h0000_0020);
      rcmd(2'h1, 5'h0b);
      $display("test scope done");
      hw_reset();
      ev(1, 5'h02, 1'b1);
      ev(0, 5'h02, 1'b0);
      look();
      chk_word(32'(hits[5]), 12);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      chk_word(32'(q[15:13]), 32'h0000_0001);
      rcmd(2'h0, 5'h02);
      look();
      chk_word(32'(hits[0]), 12);
      key(1);
      chk_bit(sil_seen, 1'b1);
      chk_bit(lmp_q, 1'b1);
      key(2);
      chk_bit(rst_seen, 1'b1);
      look();
      chk_word(32'(hits[0]), 0);
      $display("test keys done");
      tally_and_finish();
   end
endmodule
